// ===== design/power_mode_pkg.sv
// Package: constants, modes and carriers of the power mode controller
package power_mode_pkg;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_FREQ_HZ      = 250_000_000;
   localparam int unsigned WAKE_BASE_HZ     = 1_000;
   localparam int unsigned WAKE_BASE_CYCLES = CLK_FREQ_HZ / WAKE_BASE_HZ;
   localparam int unsigned BASE_CNT_W       = 18;
   localparam int unsigned SYNC_STAGES      = 3;
   localparam logic [2:0]  BOOT_CYCLES      = 3'h5;

   // ****************************************************************
   // Vectors and register map
   // ****************************************************************
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 8;
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_ACK    = 8'h01;
   localparam logic [7:0]  OFS_STATUS = 8'h02;
   localparam int unsigned ACK_BIT    = 0;
   localparam int unsigned ST_POWER_DOWN_FLAG_BIT = 0;
   localparam int unsigned ST_HOLD_BIT = 1;
   localparam logic [7:0]  CTRL_RESET = 8'h00;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [5:0] {
      MODE_BOOT  = 6'h01,
      MODE_RUN   = 6'h02,
      MODE_HALT  = 6'h04,
      MODE_WAIT  = 6'h08,
      MODE_PARTIAL_POWER_DOWN_STOP = 6'h10,
      MODE_RETENTION_STOP = 6'h20
   } mode_t;

   typedef enum logic [2:0] {
      CMD_MEM      = 3'h0,
      CMD_MEM_STAT = 3'h1,
      CMD_BDC_REG  = 3'h2,
      CMD_HALT_REQ = 3'h3,
      CMD_CPU_REG  = 3'h4,
      CMD_TRACE    = 3'h5,
      CMD_RESUME   = 3'h6
   } dbg_cmd_t;

   // Control register layout, bit 0 is stop_enable_bit
   typedef struct packed {
      logic [2:0] wakeup_period_select;
      logic       debug_in_stop_enable;
      logic       low_voltage_stop_enable;
      logic       low_voltage_detect_enable;
      logic       power_down_select;
      logic       stop_enable_bit;
   } ctrl_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic     valid;
      dbg_cmd_t kind;
   } dbg_req_t;

   typedef struct packed {
      logic accept;
      logic reject;
      logic status_err;
   } dbg_rsp_t;

   // Wake sources of the retention stop besides the periodic one
   typedef struct packed {
      logic low_voltage_detector;
      logic adc;
      logic ext_irq;
      logic keypad;
      logic serial;
   } wake_src_t;

   typedef struct packed {
      logic halt_instruction;
      logic wait_instr;
      logic stop_instr;
      logic bdc_breakpoint;
      logic module_breakpoint;
      logic irq_request;
   } cpu_evt_t;

endpackage : power_mode_pkg

// ===== design/power_mode_controller.sv
// Power mode controller: run, debug halt, wait and the two stop states
// Behaviour
// - Mode pin high at reset release: run, fetch reset vector.
// - Pin low, halt command, halt instruction or breakpoints enter halt.
// - In halt the CPU is suspended and executes no application code.
// - Memory, status, controller and halt commands work in run and halt.
// - CPU register, trace, resume only in halt; resume returns to run.
// - Wait stops CPU clock, system clocks run, interrupt mask cleared.
// - Interrupt in wait resumes with the stacking sequence.
// - Wait or stop: only halt and status commands; status reports error.
// - Halt command in wait wakes straight into halt.
// - Stop with stop enable clear forces an illegal opcode reset.
// - Stop halts clocks; select bit picks power-down or retention stop.
// - Low-voltage detector enabled in stop forces retention stop.
// - Power-down stop cuts core power except RAM; regulator in standby.
// - Pins latch on power-down entry until acknowledge written with 1.
// - Power-down wakes on reset, low interrupt pin or periodic wake.
// - Partial power-down wake restarts like power-on, pins still latched; a wake by reset clears the latch and the flag.
// - Power-down flag set on that wake until acknowledge written with 1.
// - On acknowledge pins follow their current port or peripheral logic.
// - Retention: oscillator off, generator standby, regulator standby unless LVD or debug in stop, state kept.
// - Retention exits on reset or listed interrupts, taking their vector.
// - Self-clocked 1 kHz periodic wake; period select zero disables it.
// - Debug in stop: debug clocked, regulator on, retention stop only.
//
// The address map and strobed register access were decided locally.
module power_mode_controller
   import power_mode_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = power_mode_pkg::WAKE_BASE_CYCLES
) (
   input  wire logic                        mclk_i,
   input  wire logic                        reset_n_i,
   input  wire power_mode_pkg::reg_req_t    reg_req_i,
   output logic [power_mode_pkg::DATA_W-1:0] reg_rdata_o,
   input  wire logic                        mode_select_debug_pin_i,
   input  wire logic                        external_interrupt_pin_i,
   input  wire power_mode_pkg::cpu_evt_t    cpu_evt_i,
   input  wire power_mode_pkg::wake_src_t   wake_src_i,
   input  wire power_mode_pkg::dbg_req_t    dbg_req_i,
   output power_mode_pkg::dbg_rsp_t         dbg_rsp_o,
   output power_mode_pkg::mode_t            mode_o,
   output logic                             cpu_exec_en_o,
   output logic                             sys_clock_en_o,
   output logic                             debug_clock_en_o,
   output logic                             osc_run_o,
   output logic                             clkgen_standby_o,
   output logic                             regulator_standby_o,
   output logic                             core_power_o,
   output logic                             pin_hold_o,
   output logic                             power_down_flag_o,
   output logic                             wake_source_run_o,
   output logic                             fetch_reset_vector_o,
   output logic [15:0]                      reset_vector_addr_o,
   output logic                             ccr_mask_clear_o,
   output logic                             stack_start_o,
   output logic                             illegal_opcode_reset_o,
   output logic                             periph_reset_o
);
   import power_mode_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      mode_t                  mode;
      ctrl_t                  ctrl;
      logic                   power_down_flag;
      logic                   hold;
      logic [SYNC_STAGES-1:0] ms_sync;
      logic [SYNC_STAGES-1:0] irq_sync;
      logic                   ms_f;
      logic                   irq_f;
      logic [2:0]             boot_cnt;
      logic [BASE_CNT_W-1:0]  base_cnt;
      logic [6:0]             tick_cnt;
      logic [DATA_W-1:0]      rdata;
      dbg_rsp_t               rsp;
      logic                   fetch_vec;
      logic                   ccr_clr;
      logic                   stack;
      logic                   illegal;
      logic                   periph_rst;
   } state_t;

   localparam state_t STATE_RESET = '{
      mode:     MODE_BOOT,
      ctrl:     ctrl_t'(CTRL_RESET),
      ms_sync:  '1,
      irq_sync: '1,
      ms_f:     1'b1,
      irq_f:    1'b1,
      default:  '0
   };

   state_t q;
   state_t next_q;
   logic   rti_wake;
   logic   lvd_in_stop;
   logic   in_stop;
   logic   cmd_ok;
   logic [6:0] tick_limit;

   // ****************************************************************
   // Periodic wake base and decode
   // ****************************************************************
   // The 1 kHz base is modelled by dividing the bus clock; in silicon
   // it runs from its own oscillator while every other clock is off.
   always_comb begin
      tick_limit  = 7'h01 << (q.ctrl.wakeup_period_select - 3'h1);
      rti_wake    = (q.ctrl.wakeup_period_select != 3'h0)
                    && (q.base_cnt == BASE_CNT_W'(WAKE_CYCLES - 1))
                    && (q.tick_cnt == tick_limit - 7'h01);
      lvd_in_stop = q.ctrl.low_voltage_detect_enable
                    && q.ctrl.low_voltage_stop_enable;
      in_stop     = (q.mode == MODE_PARTIAL_POWER_DOWN_STOP) || (q.mode == MODE_RETENTION_STOP);
   end

   // ****************************************************************
   // Debug command gate
   // ****************************************************************
   always_comb begin
      cmd_ok = 1'b0;
      case (q.mode)
         MODE_HALT: cmd_ok = 1'b1;
         MODE_RUN:  cmd_ok = (dbg_req_i.kind == CMD_MEM)
                             || (dbg_req_i.kind == CMD_MEM_STAT)
                             || (dbg_req_i.kind == CMD_BDC_REG)
                             || (dbg_req_i.kind == CMD_HALT_REQ);
         MODE_WAIT: cmd_ok = (dbg_req_i.kind == CMD_HALT_REQ)
                             || (dbg_req_i.kind == CMD_MEM_STAT);
         MODE_RETENTION_STOP: cmd_ok = q.ctrl.debug_in_stop_enable
                              && ((dbg_req_i.kind == CMD_HALT_REQ)
                              || (dbg_req_i.kind == CMD_MEM_STAT));
         default:   cmd_ok = 1'b0;
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_q            = q;
      next_q.fetch_vec  = 1'b0;
      next_q.ccr_clr    = 1'b0;
      next_q.stack      = 1'b0;
      next_q.illegal    = 1'b0;
      next_q.periph_rst = 1'b0;
      next_q.rdata      = '0;
      next_q.rsp        = '0;

      // Pin synchronisers; a level counts once stages two and three agree
      next_q.ms_sync  = {q.ms_sync[SYNC_STAGES-2:0], mode_select_debug_pin_i};
      next_q.irq_sync = {q.irq_sync[SYNC_STAGES-2:0],
                         external_interrupt_pin_i};
      if (q.ms_sync[1] == q.ms_sync[2]) begin
         next_q.ms_f = q.ms_sync[2];
      end
      if (q.irq_sync[1] == q.irq_sync[2]) begin
         next_q.irq_f = q.irq_sync[2];
      end

      // Period select zero stops the wake source entirely
      if (q.ctrl.wakeup_period_select == 3'h0) begin
         next_q.base_cnt = '0;
         next_q.tick_cnt = '0;
      end else if (q.base_cnt == BASE_CNT_W'(WAKE_CYCLES - 1)) begin
         next_q.base_cnt = '0;
         next_q.tick_cnt = rti_wake ? 7'h00 : q.tick_cnt + 7'h01;
      end else begin
         next_q.base_cnt = q.base_cnt + BASE_CNT_W'(1);
      end

      // Register port; control is frozen while any stop state holds
      if (reg_req_i.wr && (reg_req_i.addr == OFS_CTRL) && !in_stop) begin
         next_q.ctrl = ctrl_t'(reg_req_i.wdata);
      end
      // A write that turns the wake source off clears it at the same edge
      if (next_q.ctrl.wakeup_period_select == 3'h0) begin
         next_q.base_cnt = '0;
         next_q.tick_cnt = '0;
      end
      if (reg_req_i.wr && (reg_req_i.addr == OFS_ACK)
          && reg_req_i.wdata[ACK_BIT]) begin
         next_q.hold = 1'b0;
         next_q.power_down_flag = 1'b0;
      end
      if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            OFS_CTRL:   next_q.rdata = q.ctrl;
            OFS_STATUS: begin
               next_q.rdata[ST_POWER_DOWN_FLAG_BIT] = q.power_down_flag;
               next_q.rdata[ST_HOLD_BIT] = q.hold;
            end
            default:    next_q.rdata = '0;
         endcase
      end

      // Debug command answer
      if (dbg_req_i.valid) begin
         next_q.rsp.accept     = cmd_ok;
         next_q.rsp.reject     = !cmd_ok;
         next_q.rsp.status_err = cmd_ok && (dbg_req_i.kind == CMD_MEM_STAT)
                                 && (q.mode != MODE_RUN)
                                 && (q.mode != MODE_HALT);
      end

      case (q.mode)
         MODE_BOOT: begin
            // Boot outlasts the pin filter, so a level held through reset
            // is the one that picks the mode
            next_q.boot_cnt = q.boot_cnt + 3'h1;
            if (q.boot_cnt == BOOT_CYCLES - 3'h1) begin
               next_q.boot_cnt = '0;
               if (q.ms_f) begin
                  next_q.mode      = MODE_RUN;
                  next_q.fetch_vec = 1'b1;
               end else begin
                  next_q.mode = MODE_HALT;
               end
            end
         end
         MODE_RUN: begin
            if (dbg_req_i.valid && (dbg_req_i.kind == CMD_HALT_REQ)
                || cpu_evt_i.halt_instruction || cpu_evt_i.bdc_breakpoint
                || cpu_evt_i.module_breakpoint) begin
               next_q.mode = MODE_HALT;
            end else if (cpu_evt_i.stop_instr) begin
               if (!q.ctrl.stop_enable_bit) begin
                  next_q.illegal = 1'b1;
               end else if (q.ctrl.power_down_select && !lvd_in_stop
                            && !q.ctrl.debug_in_stop_enable) begin
                  next_q.mode = MODE_PARTIAL_POWER_DOWN_STOP;
                  next_q.hold = 1'b1;
               end else begin
                  next_q.mode = MODE_RETENTION_STOP;
               end
            end else if (cpu_evt_i.wait_instr) begin
               next_q.mode    = MODE_WAIT;
               next_q.ccr_clr = 1'b1;
            end
         end
         MODE_HALT: begin
            if (dbg_req_i.valid && (dbg_req_i.kind == CMD_RESUME)) begin
               next_q.mode = MODE_RUN;
            end
         end
         MODE_WAIT: begin
            if (dbg_req_i.valid && (dbg_req_i.kind == CMD_HALT_REQ)) begin
               next_q.mode = MODE_HALT;
            end else if (cpu_evt_i.irq_request) begin
               next_q.mode  = MODE_RUN;
               next_q.stack = 1'b1;
            end
         end
         MODE_PARTIAL_POWER_DOWN_STOP: begin
            // The pin wakes active low whatever its earlier setup was
            if (rti_wake || !q.irq_f) begin
               next_q.mode       = MODE_BOOT;
               next_q.periph_rst = 1'b1;
               next_q.ctrl       = ctrl_t'(CTRL_RESET);
               next_q.base_cnt   = '0;
               next_q.tick_cnt   = '0;
               next_q.power_down_flag       = 1'b1;
            end
         end
         MODE_RETENTION_STOP: begin
            if (q.ctrl.debug_in_stop_enable && dbg_req_i.valid
                && (dbg_req_i.kind == CMD_HALT_REQ)) begin
               next_q.mode = MODE_HALT;
            end else if (rti_wake || (|wake_src_i)) begin
               next_q.mode  = MODE_RUN;
               next_q.stack = 1'b1;
            end
         end
         default: next_q.mode = MODE_BOOT;
      endcase
   end

   // Any reset, from the pin or the system, restarts at boot
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= STATE_RESET;
      end else begin
         q <= next_q;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign mode_o                 = q.mode;
   assign cpu_exec_en_o          = (q.mode == MODE_RUN);
   assign sys_clock_en_o         = !in_stop;
   assign debug_clock_en_o       = !in_stop || ((q.mode == MODE_RETENTION_STOP)
                                   && q.ctrl.debug_in_stop_enable);
   assign osc_run_o              = !in_stop;
   assign clkgen_standby_o       = (q.mode == MODE_RETENTION_STOP);
   assign regulator_standby_o    = (q.mode == MODE_PARTIAL_POWER_DOWN_STOP)
                                   || ((q.mode == MODE_RETENTION_STOP) && !lvd_in_stop
                                   && !q.ctrl.debug_in_stop_enable);
   assign core_power_o           = (q.mode != MODE_PARTIAL_POWER_DOWN_STOP);
   // Once released, pins follow whatever the port logic now drives
   assign pin_hold_o             = q.hold;
   assign power_down_flag_o      = q.power_down_flag;
   assign wake_source_run_o      = (q.ctrl.wakeup_period_select != 3'h0);
   assign fetch_reset_vector_o   = q.fetch_vec;
   assign reset_vector_addr_o    = RESET_VECTOR_ADDR;
   assign ccr_mask_clear_o       = q.ccr_clr;
   assign stack_start_o          = q.stack;
   assign illegal_opcode_reset_o = q.illegal;
   assign periph_reset_o         = q.periph_rst;
   assign reg_rdata_o            = q.rdata;
   assign dbg_rsp_o              = q.rsp;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   a_boot_to_run: assert property (
      (q.mode == MODE_BOOT) && (q.boot_cnt == BOOT_CYCLES - 3'h1) && q.ms_f
      |=> (q.mode == MODE_RUN) && fetch_reset_vector_o)
      else $error("boot with pin high did not reach run");
   a_boot_to_halt: assert property (
      (q.mode == MODE_BOOT) && (q.boot_cnt == BOOT_CYCLES - 3'h1) && !q.ms_f
      |=> (q.mode == MODE_HALT))
      else $error("boot with pin low did not reach halt");
   a_halt_no_exec: assert property (
      (q.mode == MODE_HALT) |-> !cpu_exec_en_o)
      else $error("cpu executes in halt");
   a_active_cmd_gate: assert property (
      dbg_req_i.valid && (dbg_req_i.kind == CMD_TRACE)
      && (q.mode != MODE_HALT) |=> dbg_rsp_o.reject && !dbg_rsp_o.accept)
      else $error("trace accepted outside halt");
   a_wait_entry: assert property (
      (q.mode == MODE_RUN) && cpu_evt_i.wait_instr && !cpu_evt_i.stop_instr
      && !cpu_evt_i.halt_instruction && !cpu_evt_i.bdc_breakpoint
      && !cpu_evt_i.module_breakpoint && !dbg_req_i.valid
      |=> (q.mode == MODE_WAIT) && ccr_mask_clear_o && sys_clock_en_o
      ##1 !ccr_mask_clear_o)
      else $error("wait entry wrong");
   a_wait_status_err: assert property (
      (q.mode == MODE_WAIT) && dbg_req_i.valid
      && (dbg_req_i.kind == CMD_MEM_STAT)
      |=> dbg_rsp_o.accept && dbg_rsp_o.status_err)
      else $error("memory status in wait gave no error");
   a_stop_illegal: assert property (
      $rose(illegal_opcode_reset_o) |-> $past(q.mode) == MODE_RUN
      && !$past(q.ctrl.stop_enable_bit) && (q.mode == MODE_RUN))
      else $error("illegal reset without disabled stop");
   a_lvd_retention: assert property (
      (q.mode == MODE_PARTIAL_POWER_DOWN_STOP) |-> !lvd_in_stop
      && !q.ctrl.debug_in_stop_enable && !core_power_o)
      else $error("partial power down entered while blocked");
   a_hold_until_ack: assert property (
      pin_hold_o && !(reg_req_i.wr && (reg_req_i.addr == OFS_ACK)
      && reg_req_i.wdata[ACK_BIT]) |=> pin_hold_o)
      else $error("pin hold dropped without acknowledge");
   a_partial_power_down_stop_wake: assert property (
      (q.mode == MODE_PARTIAL_POWER_DOWN_STOP) && !q.irq_f
      |=> (q.mode == MODE_BOOT) && power_down_flag_o && periph_reset_o)
      else $error("partial power down wake wrong");
   a_rti_off: assert property (
      (q.ctrl.wakeup_period_select == 3'h0) |-> !rti_wake
      && (q.base_cnt == '0))
      else $error("periodic wake runs while disabled");

   c_partial_power_down_stop_cycle: cover property (
      (q.mode == MODE_PARTIAL_POWER_DOWN_STOP) ##[1:1000] (q.mode == MODE_BOOT));
   c_retention_stop_irq: cover property (
      (q.mode == MODE_RETENTION_STOP) ##1 stack_start_o);
   c_wait_halt: cover property (
      (q.mode == MODE_WAIT) ##1 (q.mode == MODE_HALT));

endmodule // power_mode_controller

// ===== tb/power_mode_host.sv
// Debug host and wake pin model facing the mode controller
module power_mode_host
   import power_mode_pkg::*;
(
   input  wire logic                 mclk_i,
   output power_mode_pkg::dbg_req_t  dbg_req_o,
   output logic                      mode_pin_o,
   output logic                      ext_pin_o,
   output power_mode_pkg::wake_src_t wake_src_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Both pins rest high through their pull-ups
   initial begin
      dbg_req_o  = '0;
      mode_pin_o = 1'b1;
      ext_pin_o  = 1'b1;
      wake_src_o = '0;
   end
   // Any kind may be sent in any mode; the device must sort them
   task automatic send(input dbg_cmd_t kind);
      @(posedge mclk_i);
      dbg_req_o <= '{valid: 1'b1, kind: kind};
      @(posedge mclk_i);
      dbg_req_o <= '0;
   endtask
endmodule // power_mode_host

// ===== tb/test_power_mode_controller.sv
// Self-checking bench of the power mode controller
module test_power_mode_controller;
   timeunit 1ns;
   timeprecision 1ps;
   import power_mode_pkg::*;
   logic        mclk_i, reset_n_i, rd_d, mode_select_debug_pin_i;
   logic        external_interrupt_pin_i, cpu_exec_en_o, sys_clock_en_o;
   logic        debug_clock_en_o, osc_run_o, clkgen_standby_o, core_power_o;
   logic        regulator_standby_o, pin_hold_o, power_down_flag_o;
   logic        wake_source_run_o, fetch_reset_vector_o, ccr_mask_clear_o;
   logic        stack_start_o, illegal_opcode_reset_o, periph_reset_o;
   logic [7:0]  reg_rdata_o, rd_q[$], lfsr;
   logic [15:0] reset_vector_addr_o;
   logic [2:0]  rsp_q[$];
   reg_req_t    reg_req_i;
   cpu_evt_t    cpu_evt_i;
   wake_src_t   wake_src_i;
   dbg_req_t    dbg_req_i;
   dbg_rsp_t    dbg_rsp_o;
   mode_t       mode_o;
   int          mismatches, checks;
   power_mode_controller #(.WAKE_CYCLES(8)) dut_u (.mclk_i, .reset_n_i,
      .reg_req_i, .reg_rdata_o, .mode_select_debug_pin_i, .cpu_evt_i,
      .external_interrupt_pin_i, .wake_src_i, .dbg_req_i, .dbg_rsp_o,
      .mode_o, .cpu_exec_en_o, .sys_clock_en_o, .debug_clock_en_o,
      .osc_run_o, .clkgen_standby_o, .regulator_standby_o, .core_power_o,
      .pin_hold_o, .power_down_flag_o, .wake_source_run_o,
      .fetch_reset_vector_o, .reset_vector_addr_o, .ccr_mask_clear_o,
      .stack_start_o, .illegal_opcode_reset_o, .periph_reset_o);
   power_mode_host host_u (.mclk_i, .dbg_req_o(dbg_req_i),
      .mode_pin_o(mode_select_debug_pin_i),
      .ext_pin_o(external_interrupt_pin_i), .wake_src_o(wake_src_i));
   // ****
   // Checking
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // An answer still owed at the end counts as a mismatch
   task automatic end_sim();
      if (rsp_q.size() != 0 || rd_q.size() != 0)
         mismatches++;
      if (mismatches == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge mclk_i) rd_d <= reg_req_i.rd;
   // A response with nothing queued compares against an impossible value
   always @(negedge mclk_i) begin
      if ((dbg_rsp_o.accept | dbg_rsp_o.reject) === 1'b1)
         chk(dbg_rsp_o, rsp_q.size() ? rsp_q.pop_front() : 3'h7);
      if (rd_d)
         chk(reg_rdata_o, rd_q.size() ? rd_q.pop_front() : 8'hee);
   end
   // ****
   // Drivers
   // ****
   task automatic bus(input logic [7:0] a, d, input logic w);
      if (!w)
         rd_q.push_back(d);
      @(posedge mclk_i);
      reg_req_i <= '{a, w ? d : 8'h00, w, !w};
      @(posedge mclk_i);
      reg_req_i <= '0;
   endtask
   task automatic cmd(input dbg_cmd_t k, input logic [2:0] e);
      rsp_q.push_back(e);
      host_u.send(k);
   endtask
   task automatic pulse(input cpu_evt_t e);
      @(posedge mclk_i);
      cpu_evt_i <= e;
      @(posedge mclk_i);
      cpu_evt_i <= '0;
   endtask
   task automatic wmode(input mode_t m);
      @(negedge mclk_i);
      for (int i = 0; i < 60 && mode_o !== m; i++)
         @(negedge mclk_i);
      chk(mode_o, m);
   endtask
   task automatic rst();
      reset_n_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      reset_n_i <= 1'b1;
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   initial begin
      #40000;
      mismatches++;
      end_sim();
   end
   initial begin
      reset_n_i = 1'b0;
      reg_req_i = '0;
      cpu_evt_i = '0;
      lfsr = 8'd20;
      rst();
      wmode(MODE_RUN);
      chk(fetch_reset_vector_o, 1);
      chk(reset_vector_addr_o, 16'hfffe);
      for (int k = 0; k < 7; k++)
         if (k != 3) cmd(dbg_cmd_t'(k), k < 3 ? 3'h4 : 3'h2);
      cmd(CMD_HALT_REQ, 3'h4);
      wmode(MODE_HALT);
      chk(cpu_exec_en_o, 0);
      for (int k = 0; k < 6; k++)
         cmd(dbg_cmd_t'(k), 3'h4);
      for (int i = 0; i < 4; i++) begin
         cmd(CMD_RESUME, 3'h4);
         wmode(MODE_RUN);
         if (i < 3) pulse(i == 0 ? 6'h20 : 6'h04 >> (i - 1));
         if (i < 3) wmode(MODE_HALT);
      end
      pulse(6'h10);
      wmode(MODE_WAIT);
      chk(ccr_mask_clear_o, 1);
      chk(sys_clock_en_o & ~cpu_exec_en_o, 1);
      for (int k = 0; k < 7; k++)
         if (k != 3) cmd(dbg_cmd_t'(k), k == 1 ? 3'h5 : 3'h2);
      pulse(6'h01);
      wmode(MODE_RUN);
      chk(stack_start_o, 1);
      pulse(6'h10);
      wmode(MODE_WAIT);
      cmd(CMD_HALT_REQ, 3'h4);
      wmode(MODE_HALT);
      cmd(CMD_RESUME, 3'h4);
      wmode(MODE_RUN);
      pulse(6'h08);
      @(negedge mclk_i);
      chk(illegal_opcode_reset_o, 1);
      wmode(MODE_RUN);
      lfsr = lfsr_next(lfsr);
      bus({lfsr[7:2], 2'h3}, 8'h00, 1'b0);
      bus(OFS_CTRL, 8'h03, 1'b1);
      pulse(6'h08);
      wmode(MODE_PARTIAL_POWER_DOWN_STOP);
      chk({core_power_o, regulator_standby_o, sys_clock_en_o}, 3'h2);
      chk(pin_hold_o, 1);
      host_u.ext_pin_o <= 1'b0;
      wmode(MODE_BOOT);
      chk({periph_reset_o, power_down_flag_o}, 2'h3);
      host_u.ext_pin_o <= 1'b1;
      wmode(MODE_RUN);
      chk(fetch_reset_vector_o, 1);
      bus(OFS_STATUS, 8'h03, 1'b0);
      bus(OFS_CTRL, 8'h00, 1'b0);
      bus(OFS_ACK, 8'h01, 1'b1);
      bus(OFS_STATUS, 8'h00, 1'b0);
      for (int i = 0; i < 8; i++) begin
         bus(OFS_CTRL, i == 5 ? 8'h0f : i > 5 ? 8'h21 : 8'h01, 1'b1);
         @(negedge mclk_i);
         chk(wake_source_run_o, i > 5);
         pulse(6'h08);
         wmode(MODE_RETENTION_STOP);
         chk({osc_run_o, clkgen_standby_o}, 2'h1);
         chk(regulator_standby_o, i != 5);
         repeat (i > 5 ? 10 : 30) @(negedge mclk_i);
         chk(mode_o, i > 5 ? MODE_RUN : MODE_RETENTION_STOP);
         @(posedge mclk_i);
         if (i < 6) host_u.wake_src_o <= 5'h01 << (i % 5);
         wmode(MODE_RUN);
         host_u.wake_src_o <= '0;
      end
      bus(OFS_CTRL, 8'h13, 1'b1);
      pulse(6'h08);
      wmode(MODE_RETENTION_STOP);
      chk({debug_clock_en_o, regulator_standby_o}, 2'h2);
      cmd(CMD_MEM_STAT, 3'h5);
      cmd(CMD_HALT_REQ, 3'h4);
      wmode(MODE_HALT);
      host_u.mode_pin_o <= 1'b0;
      rst();
      wmode(MODE_HALT);
      end_sim();
   end
endmodule // test_power_mode_controller
